/* bench/remote_sequencer.sv */
`timescale 1ns/100ps
module remote_sequencer (
	input wire logic sys_clk_i,
	output logic [remote_status_pkg::NUM_CMD-1:0] remote_cmd_o,
	output logic [remote_status_pkg::SEL_W-1:0] arm_select_o,
	output logic [remote_status_pkg::SEL_W-1:0] program_set_o
);
	// ****************************************
	// Sequencer pins
	// ****************************************
	initial begin
		remote_cmd_o = '0;
		arm_select_o = remote_status_pkg::DEFAULT_ARM;
		program_set_o = remote_status_pkg::DEFAULT_SET;
	end

	task automatic select(input logic [remote_status_pkg::SEL_W-1:0] arm,
			input logic [remote_status_pkg::SEL_W-1:0] set_no);
		@(negedge sys_clk_i);
		arm_select_o = arm;
		program_set_o = set_no;
	endtask

	// single held pulse
	// Several bits or a short hold are only asked for by refusal scenarios
	task automatic pulse(input logic [remote_status_pkg::NUM_CMD-1:0] mask, input int hold);
		@(negedge sys_clk_i);
		remote_cmd_o = mask;
		repeat (hold) @(negedge sys_clk_i);
		remote_cmd_o = '0;
	endtask
endmodule

/* bench/remote_status_io_tb_top.sv */
`timescale 1ns/100ps
module remote_status_io_tb_top;
	// Shortened time base keeps each pulse within a few dozen clocks
	localparam int MS = 4;
	localparam int PMS = 3;
	localparam int HOLD = (PMS + 3) * MS;
	localparam int SHORT = (PMS - 1) * MS - 2;

	logic sys_clk_i;
	logic reset_i;
	logic [remote_status_pkg::NUM_CMD-1:0] remote_cmd;
	logic [remote_status_pkg::SEL_W-1:0] arm_sel;
	logic [remote_status_pkg::SEL_W-1:0] set_sel;
	remote_status_pkg::arm_status_type arm_st;
	remote_status_pkg::ctrl_status_type ctrl_st;
	logic [remote_status_pkg::NUM_CMD-1:0] issued_cmd;
	logic [remote_status_pkg::SEL_W-1:0] issued_arm;
	logic [remote_status_pkg::SEL_W-1:0] issued_set;
	remote_status_pkg::status_type st;
	remote_status_pkg::status_type exp;
	logic [remote_status_pkg::NUM_CMD-1:0] seen_cmd;
	logic [remote_status_pkg::NUM_CMD-1:0] m;
	logic [remote_status_pkg::SEL_W-1:0] seen_arm;
	logic [remote_status_pkg::SEL_W-1:0] seen_set;
	logic seen_busy;
	int seen_count;
	int errors;
	int samples_checked;

	remote_sequencer i_seq (
		.sys_clk_i(sys_clk_i),
		.remote_cmd_o(remote_cmd),
		.arm_select_o(arm_sel),
		.program_set_o(set_sel)
	);

	remote_status_io #(
		.MS_CYCLES(MS),
		.PULSE_MS(PMS)
	) i_dut (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.remote_cmd_i(remote_cmd),
		.arm_select_inputs_i(arm_sel),
		.program_set_select_i(set_sel),
		.arm_status_i(arm_st),
		.ctrl_status_i(ctrl_st),
		.issued_cmd_o(issued_cmd),
		.issued_arm_o(issued_arm),
		.issued_set_o(issued_set),
		.status_o(st)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// One-cycle issue pulses are caught mid-cycle where they are settled
	always @(negedge sys_clk_i) begin
		if (issued_cmd !== '0) begin
			seen_cmd = seen_cmd | issued_cmd;
			seen_arm = issued_arm;
			seen_set = issued_set;
			seen_busy = st.command_in_progress;
			seen_count++;
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input string name, input logic [31:0] expv, input logic [31:0] got);
		samples_checked++;
		if (got !== expv) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, expv, got);
		end
	endtask

	task automatic summarize();
		if (errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic run_cmd(input logic [remote_status_pkg::NUM_CMD-1:0] mask, input int hold,
			input logic [remote_status_pkg::NUM_CMD-1:0] exp_cmd);
		seen_cmd = '0;
		seen_count = 0;
		i_seq.pulse(mask, hold);
		repeat (8) @(negedge sys_clk_i);
		check("issued_cmd", 32'(exp_cmd), 32'(seen_cmd));
		check("issue_count", (exp_cmd !== '0) ? 32'h1 : 32'h0, seen_count);
		if (exp_cmd !== '0) begin
			check("issued_arm", 32'(arm_sel), 32'(seen_arm));
			check("issued_set", 32'(set_sel), 32'(seen_set));
			check("busy_at_issue", 32'h1, 32'(seen_busy));
			ctrl_st.cmd_done = 1'b1;
			@(negedge sys_clk_i);
			ctrl_st.cmd_done = 1'b0;
			repeat (2) @(negedge sys_clk_i);
			check("busy_after_done", 32'h0, 32'(st.command_in_progress));
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset_i = 1'b1;
		arm_st = '0;
		ctrl_st = '0;
		errors = 0;
		samples_checked = 0;
		seen_cmd = '0;
		seen_count = 0;
		repeat (8) @(negedge sys_clk_i);
		check("status_in_reset", remote_status_pkg::STATUS_RESET, st);
		check("issued_in_reset", 32'h0, {issued_cmd, issued_arm, issued_set});
		reset_i = 1'b0;
		repeat (5) @(negedge sys_clk_i);
		check("status_default", remote_status_pkg::STATUS_RESET, st);

		// Arm 5 fully active, every controller level high
		i_seq.select(4'h5, 4'hA);
		arm_st.motors_on[5] = 1'b1;
		arm_st.power_high[5] = 1'b1;
		arm_st.absolute_enc[5] = 1'b1;
		arm_st.at_home[5] = 1'b1;
		// Every level high; the done and fault pulses stay low
		ctrl_st = 11'h7FC;
		repeat (6) @(negedge sys_clk_i);
		exp = '1;
		exp.command_in_progress = 1'b0;
		exp.error_latched = 1'b0;
		exp.remote_accept_mode = 1'b0;
		exp.current_arm_bit3 = 1'b0;
		exp.current_arm_bit1 = 1'b0;
		exp.current_program_set_bit2 = 1'b0;
		exp.current_program_set_bit0 = 1'b0;
		exp.motor_user_setting = 1'b0;
		exp.power_user_setting = 1'b0;
		check("status_arm5", exp, st);

		// Arm 10 idle but calibrated; pause without running tasks; switch outside teach
		i_seq.select(4'hA, 4'h5);
		arm_st.calibrated[10] = 1'b1;
		ctrl_st = '0;
		ctrl_st.tasks_paused = 1'b1;
		ctrl_st.enable_switch = 1'b1;
		ctrl_st.remote_enabled = 1'b1;
		repeat (6) @(negedge sys_clk_i);
		exp = remote_status_pkg::STATUS_RESET;
		exp.calibration_done = 1'b1;
		exp.remote_accept_mode = 1'b1;
		exp.current_arm_bit3 = 1'b1;
		exp.current_arm_bit1 = 1'b1;
		exp.current_program_set_bit2 = 1'b1;
		exp.current_program_set_bit0 = 1'b1;
		check("status_arm10", exp, st);

		// Every command once; power stays forced low and motors stay off except for power high
		i_seq.select(4'h3, 4'h6);
		arm_st = '0;
		ctrl_st.tasks_paused = 1'b0;
		for (int c = 0; c < remote_status_pkg::NUM_CMD; c++) begin
			ctrl_st.tasks_running = remote_status_pkg::RUN_ONLY_MASK[c];
			arm_st.motors_on[3] = (c == remote_status_pkg::CMD_POWER_HIGH);
			m = 14'h0001 << c;
			run_cmd(m, HOLD, m);
			check("motor_user", 32'(c == 0), 32'(st.motor_user_setting));
			check("power_user", 32'(c == 2), 32'(st.power_user_setting));
		end
		ctrl_st.tasks_running = 1'b0;
		run_cmd(14'h0200, 3 * HOLD, 14'h0200);

		// Refusals
		ctrl_st.tasks_running = 1'b1;
		run_cmd(14'h0040, HOLD, 14'h0000);
		ctrl_st.tasks_running = 1'b0;
		run_cmd(14'h0080, HOLD, 14'h0000);
		// Power high needs the motors of the selected arm on
		run_cmd(14'h0004, HOLD, 14'h0000);
		check("power_user_refused", 32'h0, 32'(st.power_user_setting));
		ctrl_st.remote_enabled = 1'b0;
		run_cmd(14'h0001, HOLD, 14'h0000);
		check("accept_disabled", 32'h0, 32'(st.remote_accept_mode));
		ctrl_st.remote_enabled = 1'b1;
		ctrl_st.teach_mode = 1'b1;
		run_cmd(14'h0020, HOLD, 14'h0000);
		ctrl_st.teach_mode = 1'b0;
		run_cmd(14'h0200, SHORT, 14'h0000);

		// Two inputs at once latch the error; only clear fault gets through
		run_cmd(14'h0003, HOLD, 14'h0000);
		check("error_multi", 32'h1, 32'(st.error_latched));
		run_cmd(14'h0200, HOLD, 14'h0000);
		check("accept_in_error", 32'h0, 32'(st.remote_accept_mode));
		run_cmd(14'h0400, HOLD, 14'h0400);
		check("error_cleared", 32'h0, 32'(st.error_latched));
		ctrl_st.fault_event = 1'b1;
		@(negedge sys_clk_i);
		ctrl_st.fault_event = 1'b0;
		repeat (20) @(negedge sys_clk_i);
		check("error_held", 32'h1, 32'(st.error_latched));
		run_cmd(14'h0400, HOLD, 14'h0400);
		check("error_cleared2", 32'h0, 32'(st.error_latched));
		summarize();
	end

	// A full run takes about a thousand clocks
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		errors++;
		summarize();
	end
endmodule

/* inc/remote_status_pkg.sv */
package remote_status_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PULSE_MIN_MS = 25;

	// ****************************************
	// Remote command inputs
	// ****************************************
	localparam int NUM_CMD = 14;
	localparam int CMD_MOTOR_ON = 0;
	localparam int CMD_MOTOR_OFF = 1;
	localparam int CMD_POWER_HIGH = 2;
	localparam int CMD_POWER_LOW = 3;
	localparam int CMD_CALIBRATE = 4;
	localparam int CMD_GO_HOME = 5;
	localparam int CMD_START = 6;
	localparam int CMD_PAUSE = 7;
	localparam int CMD_CONTINUE = 8;
	localparam int CMD_ABORT_ALL = 9;
	localparam int CMD_CLEAR_FAULT = 10;
	localparam int CMD_RECOVER = 11;
	localparam int CMD_SHUTDOWN = 12;
	localparam int CMD_REBOOT = 13;
	// Commands refused while tasks run, and commands only taken while they run
	localparam logic [NUM_CMD-1:0] IDLE_ONLY_MASK = 14'h307F;
	localparam logic [NUM_CMD-1:0] RUN_ONLY_MASK = 14'h0180;
	localparam logic [NUM_CMD-1:0] CLEAR_ONLY_MASK = 14'h0400;

	// ****************************************
	// Arm and program set selection
	// ****************************************
	localparam int SEL_W = 4;
	localparam int NUM_ARMS = 16;
	localparam logic [SEL_W-1:0] DEFAULT_ARM = 4'h0;
	localparam logic [SEL_W-1:0] DEFAULT_SET = 4'h0;

	typedef struct packed {
		logic [NUM_ARMS-1:0] motors_on;
		logic [NUM_ARMS-1:0] power_high;
		logic [NUM_ARMS-1:0] calibrated;
		logic [NUM_ARMS-1:0] absolute_enc;
		logic [NUM_ARMS-1:0] at_home;
	} arm_status_type;

	typedef struct packed {
		logic tasks_running;
		logic tasks_paused;
		logic guard_open;
		logic estop;
		logic teach_mode;
		logic enable_switch;
		logic remote_enabled;
		logic recover_needed;
		logic recover_busy;
		logic cmd_done;
		logic fault_event;
	} ctrl_status_type;

	typedef struct packed {
		logic motors_energized;
		logic high_power_active;
		logic calibration_done;
		logic at_rest_position;
		logic command_in_progress;
		logic tasks_active;
		logic tasks_suspended;
		logic guard_open;
		logic emergency_stop_active;
		logic error_latched;
		logic remote_accept_mode;
		logic manual_program_mode;
		logic deadman_held;
		logic current_arm_bit3;
		logic current_arm_bit2;
		logic current_arm_bit1;
		logic current_arm_bit0;
		logic current_program_set_bit3;
		logic current_program_set_bit2;
		logic current_program_set_bit1;
		logic current_program_set_bit0;
		logic motor_user_setting;
		logic power_user_setting;
		logic recovery_pending;
		logic recovery_in_progress;
	} status_type;

	localparam status_type STATUS_RESET = '0;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'b01,
		CMD_BUSY = 2'b10
	} cmd_state_type;

endpackage

/* rtl/remote_pulse_filter.sv */
`timescale 1ns/100ps
module remote_pulse_filter #(
	parameter int WIDTH = 14,
	parameter int MIN_TICKS = 25
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic tick_i,
	input wire logic [WIDTH-1:0] raw_i,
	output logic [WIDTH-1:0] held_o,
	output logic [WIDTH-1:0] valid_o
);
	localparam int CW = $clog2(MIN_TICKS + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(MIN_TICKS);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] valid_ff;
	logic [WIDTH-1:0] nxt_valid;
	logic [CW-1:0] cnt_ff [WIDTH];
	logic [CW-1:0] nxt_cnt [WIDTH];

	// ****************************************
	// Width qualification
	// ****************************************
	// width qualification
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			nxt_cnt[i] = cnt_ff[i];
			nxt_valid[i] = 1'b0;
			if (!sync_ff[i]) begin
				nxt_cnt[i] = '0;
			end else if (tick_i && cnt_ff[i] != CNT_MAX) begin
				nxt_cnt[i] = cnt_ff[i] + 1'b1;
				// Fires once per pulse, at the tick that completes the width
				if (cnt_ff[i] == CNT_MAX - 1'b1) begin
					nxt_valid[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
			valid_ff <= '0;
			for (int i = 0; i < WIDTH; i++) begin
				cnt_ff[i] <= '0;
			end
		end else begin
			meta_ff <= raw_i;
			sync_ff <= meta_ff;
			valid_ff <= nxt_valid;
			for (int i = 0; i < WIDTH; i++) begin
				cnt_ff[i] <= nxt_cnt[i];
			end
		end
	end

	assign held_o = sync_ff;
	assign valid_o = valid_ff;

	a_valid_needs_tick: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		|valid_ff |-> $past(tick_i))
		else $error("pulse qualified without a millisecond tick");

endmodule

/* rtl/remote_status_io.sv */
`timescale 1ns/100ps
module remote_status_io #(
	parameter int MS_CYCLES = remote_status_pkg::TICK_CYCLES,
	parameter int PULSE_MS = remote_status_pkg::PULSE_MIN_MS
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [remote_status_pkg::NUM_CMD-1:0] remote_cmd_i,
	input wire logic [remote_status_pkg::SEL_W-1:0] arm_select_inputs_i,
	input wire logic [remote_status_pkg::SEL_W-1:0] program_set_select_i,
	input wire remote_status_pkg::arm_status_type arm_status_i,
	input wire remote_status_pkg::ctrl_status_type ctrl_status_i,
	output logic [remote_status_pkg::NUM_CMD-1:0] issued_cmd_o,
	output logic [remote_status_pkg::SEL_W-1:0] issued_arm_o,
	output logic [remote_status_pkg::SEL_W-1:0] issued_set_o,
	output remote_status_pkg::status_type status_o
);
	localparam int TW = $clog2(MS_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);
	localparam int NC = remote_status_pkg::NUM_CMD;
	localparam int SW = remote_status_pkg::SEL_W;
	localparam int NA = remote_status_pkg::NUM_ARMS;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	function automatic logic more_than_one(input logic [NC-1:0] v);
		more_than_one = |(v & (v - 1'b1));
	endfunction

	// ****************************************
	// Millisecond time base
	// ****************************************
	logic [TW-1:0] tick_cnt_ff;
	logic [TW-1:0] nxt_tick_cnt;
	logic tick;

	always_comb begin
		tick = (tick_cnt_ff == TICK_LAST);
		nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end

	// ****************************************
	// Remote input capture
	// ****************************************
	logic [NC-1:0] held;
	logic [NC-1:0] valid;

	remote_pulse_filter #(
		.WIDTH(NC),
		.MIN_TICKS(PULSE_MS)
	) u_filter (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.tick_i(tick),
		.raw_i(remote_cmd_i),
		.held_o(held),
		.valid_o(valid)
	);

	// Select pins are levels; two flops each before use
	logic [SW-1:0] arm_meta_ff;
	logic [SW-1:0] arm_sync_ff;
	logic [SW-1:0] set_meta_ff;
	logic [SW-1:0] set_sync_ff;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			arm_meta_ff <= remote_status_pkg::DEFAULT_ARM;
			arm_sync_ff <= remote_status_pkg::DEFAULT_ARM;
			set_meta_ff <= remote_status_pkg::DEFAULT_SET;
			set_sync_ff <= remote_status_pkg::DEFAULT_SET;
		end else begin
			arm_meta_ff <= arm_select_inputs_i;
			arm_sync_ff <= arm_meta_ff;
			set_meta_ff <= program_set_select_i;
			set_sync_ff <= set_meta_ff;
		end
	end

	// ****************************************
	// Command acceptance
	// ****************************************
	remote_status_pkg::status_type status_ff;
	remote_status_pkg::status_type nxt_status;
	logic [NC-1:0] accepted;
	logic multi;
	logic accept_mode;

	always_comb begin
		multi = more_than_one(valid) | (|valid & more_than_one(held));
		accept_mode = ctrl_status_i.remote_enabled & ~ctrl_status_i.teach_mode;
		accepted = valid;
		if (ctrl_status_i.tasks_running) begin
			accepted = accepted & ~remote_status_pkg::IDLE_ONLY_MASK;
		end else begin
			accepted = accepted & ~remote_status_pkg::RUN_ONLY_MASK;
		end
		// nothing but clear-fault outside remote mode
		if (!accept_mode) begin
			accepted = accepted & remote_status_pkg::CLEAR_ONLY_MASK;
		end
		if (status_ff.error_latched) begin
			accepted = valid & remote_status_pkg::CLEAR_ONLY_MASK;
		end
		if (multi) begin
			accepted = '0;
		end
		// Interlocks: the opposing input must be off
		if (held[remote_status_pkg::CMD_MOTOR_OFF]) begin
			accepted[remote_status_pkg::CMD_MOTOR_ON] = 1'b0;
		end
		if (held[remote_status_pkg::CMD_POWER_LOW] || !arm_status_i.motors_on[arm_sync_ff]) begin
			accepted[remote_status_pkg::CMD_POWER_HIGH] = 1'b0;
		end
	end

	// ****************************************
	// Command tracking
	// ****************************************
	remote_status_pkg::cmd_state_type cmd_state_ff;
	remote_status_pkg::cmd_state_type nxt_cmd_state;

	// busy until the controller reports done
	always_comb begin
		nxt_cmd_state = cmd_state_ff;
		case (cmd_state_ff)
			remote_status_pkg::CMD_IDLE: begin
				if (|accepted) begin
					nxt_cmd_state = remote_status_pkg::CMD_BUSY;
				end
			end
			remote_status_pkg::CMD_BUSY: begin
				// A new command in the done cycle keeps it busy
				if (ctrl_status_i.cmd_done && !(|accepted)) begin
					nxt_cmd_state = remote_status_pkg::CMD_IDLE;
				end
			end
			default: begin
				nxt_cmd_state = remote_status_pkg::CMD_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cmd_state_ff <= remote_status_pkg::CMD_IDLE;
		end else begin
			cmd_state_ff <= nxt_cmd_state;
		end
	end

	// ****************************************
	// User settings per arm
	// ****************************************
	logic [NA-1:0] motor_user_ff;
	logic [NA-1:0] power_user_ff;
	logic [NA-1:0] nxt_motor_user;
	logic [NA-1:0] nxt_power_user;

	always_comb begin
		nxt_motor_user = motor_user_ff;
		nxt_power_user = power_user_ff;
		if (accepted[remote_status_pkg::CMD_MOTOR_ON]) begin
			nxt_motor_user[arm_sync_ff] = 1'b1;
		end
		if (accepted[remote_status_pkg::CMD_MOTOR_OFF]) begin
			nxt_motor_user[arm_sync_ff] = 1'b0;
		end
		if (accepted[remote_status_pkg::CMD_POWER_HIGH]) begin
			nxt_power_user[arm_sync_ff] = 1'b1;
		end
		if (accepted[remote_status_pkg::CMD_POWER_LOW]) begin
			nxt_power_user[arm_sync_ff] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			motor_user_ff <= '0;
			power_user_ff <= '0;
		end else begin
			motor_user_ff <= nxt_motor_user;
			power_user_ff <= nxt_power_user;
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	always_comb begin
		nxt_status = status_ff;
		// motor state of the selected arm
		nxt_status.motors_energized = arm_status_i.motors_on[arm_sync_ff];
		// high power of the selected arm
		nxt_status.high_power_active = arm_status_i.power_high[arm_sync_ff];
		nxt_status.calibration_done = arm_status_i.calibrated[arm_sync_ff]
			| arm_status_i.absolute_enc[arm_sync_ff];
		nxt_status.at_rest_position = arm_status_i.at_home[arm_sync_ff];
		nxt_status.command_in_progress = (nxt_cmd_state == remote_status_pkg::CMD_BUSY);
		nxt_status.tasks_active = ctrl_status_i.tasks_running;
		nxt_status.tasks_suspended = ctrl_status_i.tasks_running & ctrl_status_i.tasks_paused;
		nxt_status.guard_open = ctrl_status_i.guard_open;
		nxt_status.emergency_stop_active = ctrl_status_i.estop;
		// latched error, set wins over clear
		nxt_status.error_latched = (status_ff.error_latched
			& ~accepted[remote_status_pkg::CMD_CLEAR_FAULT])
			| ctrl_status_i.fault_event | multi;
		nxt_status.remote_accept_mode = accept_mode & ~nxt_status.error_latched;
		nxt_status.manual_program_mode = ctrl_status_i.teach_mode;
		nxt_status.deadman_held = ctrl_status_i.teach_mode & ctrl_status_i.enable_switch;
		// zero based, first arm is zero
		{nxt_status.current_arm_bit3, nxt_status.current_arm_bit2,
			nxt_status.current_arm_bit1, nxt_status.current_arm_bit0} = arm_sync_ff;
		{nxt_status.current_program_set_bit3, nxt_status.current_program_set_bit2,
			nxt_status.current_program_set_bit1,
			nxt_status.current_program_set_bit0} = set_sync_ff;
		nxt_status.motor_user_setting = nxt_motor_user[arm_sync_ff];
		nxt_status.power_user_setting = nxt_power_user[arm_sync_ff];
		nxt_status.recovery_pending = ctrl_status_i.recover_needed;
		nxt_status.recovery_in_progress = ctrl_status_i.recover_busy;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			status_ff <= remote_status_pkg::STATUS_RESET;
			issued_cmd_o <= '0;
			issued_arm_o <= remote_status_pkg::DEFAULT_ARM;
			issued_set_o <= remote_status_pkg::DEFAULT_SET;
		end else begin
			status_ff <= nxt_status;
			issued_cmd_o <= accepted;
			issued_arm_o <= arm_sync_ff;
			issued_set_o <= set_sync_ff;
		end
	end

	assign status_o = status_ff;

	// ****************************************
	// Checks
	// ****************************************
	a_error_holds: assert property (
		status_ff.error_latched
		|=> status_ff.error_latched || issued_cmd_o[remote_status_pkg::CMD_CLEAR_FAULT])
		else $error("error output dropped without clear-fault");

	a_multi_error: assert property (
		multi |=> status_ff.error_latched && issued_cmd_o == '0)
		else $error("simultaneous inputs did not raise error");

	a_error_ignores: assert property (
		status_ff.error_latched |=> (issued_cmd_o & ~remote_status_pkg::CLEAR_ONLY_MASK) == '0)
		else $error("command issued while in error");

	a_busy_follows: assert property (
		|accepted |=> status_ff.command_in_progress [*1] ##0 (issued_cmd_o != '0))
		else $error("accepted command not shown as in progress");

	a_arm_bits: assert property (
		##1 {status_ff.current_arm_bit3, status_ff.current_arm_bit2,
			status_ff.current_arm_bit1, status_ff.current_arm_bit0} == $past(arm_sync_ff))
		else $error("arm number outputs wrong");

	a_absolute_cal: assert property (
		arm_status_i.absolute_enc[arm_sync_ff] |=> status_ff.calibration_done)
		else $error("absolute encoder arm not shown calibrated");

	a_motor_follow: assert property (
		arm_status_i.motors_on[arm_sync_ff] |=> status_ff.motors_energized)
		else $error("motor state not reflected");

	a_deadman_teach: assert property (
		status_ff.deadman_held |-> status_ff.manual_program_mode)
		else $error("dead-man shown outside teach mode");

	a_accept_mode: assert property (
		status_ff.remote_accept_mode |-> !status_ff.manual_program_mode
			&& !status_ff.error_latched)
		else $error("accept mode shown while commands refused");

	// Both outputs lag the select by one edge, so the arm must be steady one edge back
	a_motor_user_keep: assert property (
		$fell(status_ff.motors_energized)
			&& ($past(arm_sync_ff, 1) == $past(arm_sync_ff, 2))
			&& !issued_cmd_o[remote_status_pkg::CMD_MOTOR_ON]
			&& !issued_cmd_o[remote_status_pkg::CMD_MOTOR_OFF]
		|-> $stable(status_ff.motor_user_setting))
		else $error("user motor setting changed by system");

endmodule
